// [core/grp1_handshake_config.v]
// Purpose: group 1 handshake configuration word with AXI4-Lite access
// Assumes: request pin is asynchronous; data-ready flag is same-clock
// Notes: status read clears sticky bits; irq_out is level
`timescale 1ns/1ps
`default_nettype none
`include "grp1_cfg_map.vh"

module grp1_handshake_config (
	input wire core_clk_in,
	input wire rst_n_in,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire grp1_handshake_request_in,
	input wire grp1_data_ready_flag_in,
	output reg grp1_dma_request_out,
	output reg grp1_irq_request_out,
	output reg first_port_handshake_enable_out,
	output reg second_port_handshake_enable_out,
	output reg [2:0] grp1_settle_delay_out,
	output reg grp1_request_active_out,
	output reg grp1_data_settled_out,
	output reg grp1_local_reset_out,
	output wire irq_out
);

// ****************************************************************
// bus write channel
// ****************************************************************
reg [7:0] awaddr_q;
reg aw_held_q;
reg [31:0] wdata_q;
reg [3:0] wstrb_q;
reg w_held_q;
reg [15:0] cfg_q;
reg [2:0] status_q;
reg [2:0] mask_q;

assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
assign s_axi_wready = !w_held_q && !s_axi_bvalid;

wire aw_fire_w = s_axi_awvalid && s_axi_awready;
wire w_fire_w = s_axi_wvalid && s_axi_wready;
wire aw_have_w = aw_held_q || aw_fire_w;
wire w_have_w = w_held_q || w_fire_w;
wire wr_do_w = aw_have_w && w_have_w;
wire [7:0] wr_addr_w = aw_held_q ? awaddr_q : s_axi_awaddr;
wire [31:0] wr_data_w = w_held_q ? wdata_q : s_axi_wdata;
wire [3:0] wr_strb_w = w_held_q ? wstrb_q : s_axi_wstrb;

function hit;
	input [7:0] addr;
	input [7:0] offs;
	begin
		hit = (addr[7:2] == offs[7:2]);
	end
endfunction

function [15:0] merge16;
	input [15:0] old;
	input [31:0] data;
	input [3:0] strb;
	begin
		merge16[7:0] = strb[0] ? data[7:0] : old[7:0];
		merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
	end
endfunction

wire wr_cfg_w = wr_do_w && hit(wr_addr_w, `CFG_OFFSET);
wire wr_mask_w = wr_do_w && hit(wr_addr_w, `MASK_OFFSET);
wire wr_ok_w = wr_cfg_w || wr_mask_w;

always @(posedge core_clk_in or negedge rst_n_in) begin
	if (!rst_n_in) begin
		awaddr_q <= 8'h00;
		aw_held_q <= 1'b0;
		wdata_q <= 32'h00000000;
		wstrb_q <= 4'h0;
		w_held_q <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= 2'h0;
	end else begin
		if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
		if (wr_do_w) begin
			aw_held_q <= 1'b0;
			w_held_q <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok_w ? 2'h0 : 2'h2;
		end else begin
			if (aw_fire_w) begin
				aw_held_q <= 1'b1;
				awaddr_q <= s_axi_awaddr;
			end
			if (w_fire_w) begin
				w_held_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
		end
	end
end

// ****************************************************************
// configuration word and mask
// ****************************************************************
wire [15:0] cfg_new_w = merge16(cfg_q, wr_data_w, wr_strb_w);

always @(posedge core_clk_in or negedge rst_n_in) begin
	if (!rst_n_in) begin
		cfg_q <= `CFG_RESET;
		mask_q <= 3'h0;
	end else begin
		if (wr_cfg_w) begin
			// bit 7 is never stored
			cfg_q <= cfg_new_w & `CFG_USED_MASK;
		end
		if (wr_mask_w && wr_strb_w[0]) begin
			mask_q <= wr_data_w[2:0];
		end
	end
end

wire dma_en_w = cfg_q[`BIT_DMA_EN];
wire irq_en_w = cfg_q[`BIT_IRQ_EN];
wire req_pol_w = cfg_q[`BIT_REQ_POL];
wire lreset_bit_w = cfg_q[`BIT_LOCAL_RESET];

// ****************************************************************
// local reset sequencing
// ****************************************************************
localparam [1:0] LR_IDLE = 2'h0;
localparam [1:0] LR_HELD = 2'h1;
localparam [1:0] LR_FIRE = 2'h2;
reg [1:0] lr_state_q;
reg [1:0] lr_state_d;

always @* begin
	lr_state_d = lr_state_q;
	case (lr_state_q)
	LR_IDLE: begin
		if (lreset_bit_w) begin
			lr_state_d = LR_HELD;
		end
	end
	LR_HELD: begin
		// set then cleared raises the local-reset status event; the clear runs while the bit is set
		if (!lreset_bit_w) begin
			lr_state_d = LR_FIRE;
		end
	end
	LR_FIRE: begin
		lr_state_d = lreset_bit_w ? LR_HELD : LR_IDLE;
	end
	default: begin
		lr_state_d = LR_IDLE;
	end
	endcase
end

always @(posedge core_clk_in or negedge rst_n_in) begin
	if (!rst_n_in) begin
		lr_state_q <= LR_IDLE;
	end else begin
		lr_state_q <= lr_state_d;
	end
end

wire lreset_armed_w = (lr_state_q == LR_HELD);
wire lreset_pulse_w = (lr_state_q == LR_FIRE);

// clear held without a gap until one cycle after the bit drops
wire group_clear_w = lreset_bit_w || lreset_armed_w;

// ****************************************************************
// request input and settling
// ****************************************************************
reg req_sync1_q;
reg req_sync2_q;
reg req_active_q;
wire req_active_d = req_sync2_q ^ req_pol_w;
wire timer_busy_w;
wire timer_done_w;

always @(posedge core_clk_in or negedge rst_n_in) begin
	if (!rst_n_in) begin
		req_sync1_q <= 1'b0;
		req_sync2_q <= 1'b0;
		req_active_q <= 1'b0;
	end else begin
		req_sync1_q <= grp1_handshake_request_in;
		req_sync2_q <= req_sync1_q;
		// polarity chooses the active level
		req_active_q <= group_clear_w ? 1'b0 : req_active_d;
	end
end

wire req_rise_w = req_active_d && !req_active_q && !group_clear_w;

grp1_settle_timer u_timer (
	.core_clk_in(core_clk_in),
	.rst_n_in(rst_n_in),
	.clear_in(group_clear_w),
	.start_in(req_rise_w),
	.code_in(cfg_q[`DELAY_HI:`DELAY_LO]),
	.busy_out(timer_busy_w),
	.done_out(timer_done_w)
);

// ****************************************************************
// group outputs
// ****************************************************************
always @(posedge core_clk_in or negedge rst_n_in) begin
	if (!rst_n_in) begin
		grp1_dma_request_out <= 1'b0;
		grp1_irq_request_out <= 1'b0;
		first_port_handshake_enable_out <= 1'b0;
		second_port_handshake_enable_out <= 1'b0;
		grp1_settle_delay_out <= 3'h0;
		grp1_request_active_out <= 1'b0;
		grp1_data_settled_out <= 1'b0;
		grp1_local_reset_out <= 1'b0;
	end else begin
		grp1_dma_request_out <= dma_en_w && grp1_data_ready_flag_in;
		grp1_irq_request_out <= irq_en_w && grp1_data_ready_flag_in;
		second_port_handshake_enable_out <= cfg_q[`BIT_SECOND_EN];
		first_port_handshake_enable_out <= cfg_q[`BIT_FIRST_EN];
		grp1_settle_delay_out <= cfg_q[`DELAY_HI:`DELAY_LO];
		grp1_request_active_out <= req_active_q && !group_clear_w;
		grp1_data_settled_out <= timer_done_w;
		grp1_local_reset_out <= group_clear_w;
	end
end

// ****************************************************************
// status, interrupt and read channel
// ****************************************************************
function [2:0] event_bits;
	input req;
	input settled;
	input lreset;
	begin
		event_bits = 3'h0;
		event_bits[`ST_REQUEST] = req;
		event_bits[`ST_SETTLED] = settled;
		event_bits[`ST_LRESET] = lreset;
	end
endfunction

function [31:0] read_word;
	input [7:0] addr;
	input [2:0] status;
	input [2:0] mask;
	begin
		read_word = 32'h00000000;
		if (hit(addr, `STATUS_OFFSET)) begin
			read_word = {29'h00000000, status};
		end else if (hit(addr, `MASK_OFFSET)) begin
			read_word = {29'h00000000, mask};
		end
	end
endfunction

wire rd_fire_w = s_axi_arvalid && s_axi_arready;
wire rd_status_w = rd_fire_w && hit(s_axi_araddr, `STATUS_OFFSET);
wire rd_known_w = hit(s_axi_araddr, `STATUS_OFFSET) ||
	hit(s_axi_araddr, `MASK_OFFSET) || hit(s_axi_araddr, `CFG_OFFSET);
wire [2:0] events_w = event_bits(req_rise_w, timer_done_w, lreset_pulse_w);

assign s_axi_arready = !s_axi_rvalid;
assign irq_out = |(status_q & mask_q);

always @(posedge core_clk_in or negedge rst_n_in) begin
	if (!rst_n_in) begin
		status_q <= 3'h0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= 2'h0;
	end else begin
		// a new event wins over the read clear
		status_q <= (rd_status_w ? 3'h0 : status_q) | events_w;
		if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
		if (rd_fire_w) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= read_word(s_axi_araddr, status_q, mask_q);
			s_axi_rresp <= rd_known_w ? 2'h0 : 2'h2;
		end
	end
end

endmodule
`default_nettype wire

// [core/grp1_cfg_map.vh]
// Purpose: register map and constants for the group 1 handshake block
// Assumes: AXI4-Lite slave, 32-bit data, 250 MHz core clock
// Notes: every offset, field position and timing count lives here
//
// Overview of operation
// - bit 15 set: DMA request asserted while data-ready flag set.
// - bit 14 set: interrupt request asserted while data-ready flag set.
// - bits 13-11 select settling delay, code times 100 ns, up to 700.
// - bit 10 set enables handshaking on second 8-bit port.
// - bit 9 set enables handshaking on first 8-bit port.
// - writing bit 8 set then cleared resets group handshake logic.
// - bit 7 has no function; writes to it have no effect.
// - bit 6 set: request active low; cleared: request active high.
// - write-only 16-bit configuration word at offset 00 drives the logic.
`ifndef GRP1_CFG_MAP_VH
`define GRP1_CFG_MAP_VH

// ****************************************************************
// register offsets
// ****************************************************************
`define CFG_OFFSET 8'h00
`define STATUS_OFFSET 8'h20
`define MASK_OFFSET 8'h24

// ****************************************************************
// configuration fields
// ****************************************************************
`define CFG_WIDTH 16
`define CFG_RESET 16'h0000
`define CFG_USED_MASK 16'hFF7F
`define BIT_DMA_EN 15
`define BIT_IRQ_EN 14
`define DELAY_HI 13
`define DELAY_LO 11
`define BIT_SECOND_EN 10
`define BIT_FIRST_EN 9
`define BIT_LOCAL_RESET 8
`define BIT_REQ_POL 6

// ****************************************************************
// status bits
// ****************************************************************
`define ST_WIDTH 3
`define ST_REQUEST 0
`define ST_SETTLED 1
`define ST_LRESET 2

// ****************************************************************
// timing
// ****************************************************************
`define CLK_PERIOD_PS 4000
`define DELAY_STEP_NS 100
`define DELAY_STEP_CYC ((`DELAY_STEP_NS * 1000) / `CLK_PERIOD_PS)

`endif

// [core/grp1_settle_timer.v]
// Purpose: data-settling timer for group 1 handshaking
// Assumes: core clock of 250 MHz, delay step of 100 ns
// Notes: done pulses code times step cycles after start
`timescale 1ns/1ps
`default_nettype none
`include "grp1_cfg_map.vh"

module grp1_settle_timer (
	input wire core_clk_in,
	input wire rst_n_in,
	input wire clear_in,
	input wire start_in,
	input wire [2:0] code_in,
	output wire busy_out,
	output reg done_out
);

// ****************************************************************
// delay count
// ****************************************************************
localparam [31:0] STEP_FULL = `DELAY_STEP_CYC;
localparam [9:0] STEP = STEP_FULL[9:0];
reg [9:0] count_q;
reg busy_q;
wire [9:0] load_w = STEP * {7'h00, code_in};

assign busy_out = busy_q;

always @(posedge core_clk_in or negedge rst_n_in) begin
	if (!rst_n_in) begin
		count_q <= 10'h000;
		busy_q <= 1'b0;
		done_out <= 1'b0;
	end else if (clear_in) begin
		count_q <= 10'h000;
		busy_q <= 1'b0;
		done_out <= 1'b0;
	end else begin
		done_out <= 1'b0;
		if (start_in && !busy_q) begin
			// code zero: settled at once
			if (load_w == 10'h000) begin
				done_out <= 1'b1;
			end else begin
				count_q <= load_w - 10'h001;
				busy_q <= 1'b1;
			end
		end else if (busy_q) begin
			if (count_q == 10'h000) begin
				busy_q <= 1'b0;
				done_out <= 1'b1;
			end else begin
				count_q <= count_q - 10'h001;
			end
		end
	end
end

endmodule
`default_nettype wire

// [test/grp1_handshake_config_chk.sv]
// Purpose: port checker for the group 1 handshake block
// Assumes: one clock, async active-low reset
// Notes: attached by bind below
`timescale 1ns/1ps
`default_nettype none
module grp1_handshake_config_chk (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic grp1_data_ready_flag_in,
	input wire logic grp1_dma_request_out,
	input wire logic grp1_irq_request_out,
	input wire logic first_port_handshake_enable_out,
	input wire logic second_port_handshake_enable_out,
	input wire logic [2:0] grp1_settle_delay_out,
	input wire logic grp1_local_reset_out
);
	// ****
	// assertions
	// ****
	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	sequence wr_done;
		s_axi_bvalid && s_axi_bready;
	endsequence
	dma_flag_a:
	assert property (grp1_dma_request_out |-> $past(grp1_data_ready_flag_in))
		else $error("dma request without flag");
	irq_flag_a:
	assert property (grp1_irq_request_out |-> $past(grp1_data_ready_flag_in))
		else $error("irq request without flag");
	delay_write_a:
	assert property ($changed(grp1_settle_delay_out) |-> $past(s_axi_bvalid))
		else $error("delay changed without write");
	port_en_a:
	assert property ($changed({first_port_handshake_enable_out,
		second_port_handshake_enable_out}) |-> $past(s_axi_bvalid))
		else $error("port enable changed without write");
	lreset_write_a:
	assert property ($rose(grp1_local_reset_out) |-> $past(s_axi_bvalid))
		else $error("local reset without write");
	resp_hold_a:
	assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped");
	resp_once_a:
	assert property (wr_done |=> !s_axi_bvalid)
		else $error("write response repeated");
	rdata_hold_a:
	assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read data dropped");
endmodule
bind grp1_handshake_config grp1_handshake_config_chk u_chk (.core_clk_in,
	.rst_n_in, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready,
	.grp1_data_ready_flag_in, .grp1_dma_request_out, .grp1_irq_request_out,
	.first_port_handshake_enable_out, .second_port_handshake_enable_out,
	.grp1_settle_delay_out, .grp1_local_reset_out);
`default_nettype wire

// [test/host_master.sv]
// Purpose: host software model, AXI4-Lite master
// Assumes: caller enters xfer just after a rising edge
// Notes: stall delays bready or rready by that many cycles
`timescale 1ns/1ps
`default_nettype none
module host_master (
	input wire logic core_clk_in,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	output var logic [7:0] s_axi_awaddr,
	output var logic s_axi_awvalid,
	output var logic [31:0] s_axi_wdata,
	output var logic [3:0] s_axi_wstrb,
	output var logic s_axi_wvalid,
	output var logic s_axi_bready,
	output var logic [7:0] s_axi_araddr,
	output var logic s_axi_arvalid,
	output var logic s_axi_rready,
	output var logic hung_out
);
	int stall;
	// ****
	// bus transfer, one at a time; software rewrites fields itself
	// ****
	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
		{s_axi_bready, s_axi_rready, hung_out} = 3'h0;
		s_axi_wstrb = 4'hF;
		stall = 0;
	end
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		logic ta, tw, tk;
		int n;
		n = 0;
		tk = 1'b0;
		s_axi_awaddr <= a;
		s_axi_araddr <= a;
		s_axi_wdata <= d;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {w, w, !w};
		while (!tk && n < 99) begin
			@(negedge core_clk_in);
			ta = w ? s_axi_awready : s_axi_arready;
			tw = s_axi_wready;
			tk = w ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready;
			@(posedge core_clk_in);
			if (ta) {s_axi_awvalid, s_axi_arvalid} <= 2'h0;
			if (tw) s_axi_wvalid <= 1'b0;
			n++;
			if (!tk && n >= stall) {s_axi_bready, s_axi_rready} <= {w, !w};
		end
		{s_axi_bready, s_axi_rready} <= 2'h0;
		if (!tk) hung_out <= 1'b1;
	endtask
endmodule
`default_nettype wire

// [test/grp1_handshake_config_tb.sv]
// Purpose: self-checking bench for the group 1 handshake block
// Assumes: 250 MHz clock, queue of expected bus answers
// Notes: bus answers checked by the negedge monitor
`timescale 1ns/1ps
`default_nettype none
module grp1_handshake_config_tb;
	logic core_clk_in, rst_n_in, hung;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic grp1_handshake_request_in, grp1_data_ready_flag_in;
	logic grp1_dma_request_out, grp1_irq_request_out, irq_out;
	logic first_port_handshake_enable_out, second_port_handshake_enable_out;
	logic [2:0] grp1_settle_delay_out;
	logic grp1_request_active_out, grp1_data_settled_out, grp1_local_reset_out;
	logic [65:0] exp_q[$];
	logic [65:0] e;
	int bad_count, samples_checked;
	int n;
	logic [2:0] c;
	grp1_handshake_config u_grp1_handshake_config (.core_clk_in, .rst_n_in,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.grp1_handshake_request_in, .grp1_data_ready_flag_in,
		.grp1_dma_request_out, .grp1_irq_request_out,
		.first_port_handshake_enable_out, .second_port_handshake_enable_out,
		.grp1_settle_delay_out, .grp1_request_active_out,
		.grp1_data_settled_out, .grp1_local_reset_out, .irq_out);
	host_master u_host (.core_clk_in, .s_axi_awready, .s_axi_wready,
		.s_axi_bvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_rready,
		.hung_out(hung));
	// ****
	// helpers
	// ****
	task automatic chk(input string n, input logic [33:0] s, x);
		samples_checked++;
		if (s !== x) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic op(input logic w, input logic [7:0] a,
		input logic [31:0] x, m, input logic [1:0] r);
		@(posedge core_clk_in);
		exp_q.push_back({r, m, x & m});
		u_host.xfer(w, a, x);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_in);
		@(negedge core_clk_in);
	endtask
	task automatic end_of_test;
		if (bad_count == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		core_clk_in = 1'b0;
		forever #2 core_clk_in = ~core_clk_in;
	end
	always @(negedge core_clk_in) begin
		if ((s_axi_bvalid && s_axi_bready) || (s_axi_rvalid && s_axi_rready)) begin
			e = exp_q.pop_front();
			chk("resp", {s_axi_bvalid ? s_axi_bresp : s_axi_rresp,
				s_axi_rdata & e[63:32]}, {e[65:64], e[31:0]});
		end
	end
	always @(posedge hung) begin
		bad_count++;
		end_of_test;
	end
	// ****
	// scenarios
	// ****
	initial begin
		rst_n_in = 1'b0;
		grp1_handshake_request_in = 1'b0;
		grp1_data_ready_flag_in = 1'b0;
		d = $urandom(32'h60F7);
		repeat (3) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			d = ($urandom & 32'h0001_C7FF) | (i << 11);
			u_host.stall = i % 3;
			@(posedge core_clk_in);
			grp1_data_ready_flag_in <= d[16];
			op(1'b1, 8'h00, d, 32'h0, 2'h0);
			tick(1);
			chk("dma", grp1_dma_request_out, d[15] & d[16]);
			chk("irq", grp1_irq_request_out, d[14] & d[16]);
			chk("dly", grp1_settle_delay_out, d[13:11]);
			chk("pb", second_port_handshake_enable_out, d[10]);
			chk("pa", first_port_handshake_enable_out, d[9]);
		end
		@(posedge core_clk_in);
		grp1_data_ready_flag_in <= 1'b1;
		op(1'b1, 8'h00, 32'h0000_C000, 32'h0, 2'h0);
		tick(0);
		chk("dma", grp1_dma_request_out, 1'b1);
		chk("irq", grp1_irq_request_out, 1'b1);
		@(posedge core_clk_in);
		grp1_data_ready_flag_in <= 1'b0;
		tick(1);
		chk("dma", grp1_dma_request_out, 1'b0);
		chk("irq", grp1_irq_request_out, 1'b0);
		op(1'b1, 8'h00, 32'h0000_0100, 32'h0, 2'h0);
		tick(1);
		chk("lrst", grp1_local_reset_out, 1'b1);
		op(1'b1, 8'h00, 32'h0, 32'h0, 2'h0);
		tick(3);
		chk("lrst", grp1_local_reset_out, 1'b0);
		op(1'b0, 8'h20, 32'h0000_0004, 32'h0000_0004, 2'h0);
		for (int p = 0; p < 4; p++) begin
			op(1'b1, 8'h00, {25'h0, p[1], 6'h00}, 32'h0, 2'h0);
			@(posedge core_clk_in);
			grp1_handshake_request_in <= p[0];
			tick(6);
			chk("act", grp1_request_active_out, p[0] ^ p[1]);
		end
		op(1'b1, 8'h24, 32'h0, 32'h0, 2'h0);
		op(1'b1, 8'h00, 32'h0, 32'h0, 2'h0);
		tick(6);
		chk("irq", irq_out, 1'b0);
		op(1'b1, 8'h24, 32'h1, 32'h0, 2'h0);
		tick(1);
		chk("irq", irq_out, 1'b1);
		@(posedge core_clk_in);
		grp1_handshake_request_in <= 1'b0;
		op(1'b0, 8'h24, 32'h1, 32'hFFFF_FFFF, 2'h0);
		op(1'b0, 8'h20, 32'h1, 32'h1, 2'h0);
		tick(1);
		chk("irq", irq_out, 1'b0);
		c = 3'($urandom_range(7, 1));
		op(1'b1, 8'h00, {18'h0, c, 11'h000}, 32'h0, 2'h0);
		@(posedge core_clk_in);
		grp1_handshake_request_in <= 1'b1;
		// 100 ns steps of the 4 ns clock, plus sync and output edges
		for (n = 1; n < 300; n++) begin
			tick(1);
			if (grp1_data_settled_out === 1'b1) break;
		end
		chk("settle", n, c * 100 / 4 + 4);
		op(1'b1, 8'h10, 32'h0000_FFFF, 32'h0, 2'h2);
		op(1'b1, 8'h20, 32'h0, 32'h0, 2'h2);
		op(1'b0, 8'h00, 32'h0, 32'hFFFF_FFFF, 2'h0);
		op(1'b0, 8'h30, 32'h0, 32'hFFFF_FFFF, 2'h2);
		tick(2);
		chk("dly", grp1_settle_delay_out, c);
		end_of_test;
	end
endmodule
`default_nettype wire
